// ==== queue_dma_usb_ata_bridge.sv ====
/*
 * Four-channel queue engine between USB endpoints, a shared buffer RAM and
 * storage/card ports, with endpoint mapping and storage mode setting.
 * Assumes one 25 MHz clock, synchronous active-low reset, and peripherals
 * on the same clock offering valid/ready byte streams.
 */
// Function
// - four channels, each selecting a request source
// - fixed priority, channel one highest
// - channels pair into double buffers
// - peripheral-to-peripheral only in pass-through mode
// - source codes: USB, storage, four cards
// - RAM window opens after placement key
// - data moves without processor per word
// - physical zero and one are control
// - physical two-five map, one on three
// - endpoints four, five buffer in RAM
// - other endpoints have own 64 bytes
// - only logical endpoint numbers reach host
// - storage modes PIO and UDMA 0-4
`timescale 1ns/10ps
module queue_dma_usb_ata_bridge #(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_b_in,
   input  wire logic [15:0]           reg_addr_in,
   input  wire logic [15:0]           reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic      [15:0]           reg_rdata_out,
   input  wire logic [11:0]           src_valid_in,
   input  wire logic [11:0][7:0]      src_data_in,
   output logic      [11:0]           src_ready_out,
   output logic      [11:0]           dst_valid_out,
   output logic      [7:0]            dst_data_out,
   input  wire logic [11:0]           dst_ready_in,
   input  wire logic [2:0]            usb_phys_ep_in,
   input  wire logic                  usb_high_speed_in,
   output logic      [1:0]            usb_logical_ep_out,
   output logic      [9:0]            ep_buf_size_out,
   output logic                       ep_in_queue_out,
   output qdma_pkg::stor_mode_t       storage_mode_out,
   output logic      [3:0]            channel_grant_out
);
   if (FIFO_DEPTH < 2) begin : g_chk
      $error("queue_dma_usb_ata_bridge: FIFO_DEPTH too small");
   end

   function automatic logic [11:0] one_hot12(input logic [3:0] code);
      one_hot12 = (code <= qdma_pkg::SRC_LAST) ? (12'h001 << code) : 12'h000;
   endfunction

   function automatic logic [2:0] count3(input logic [7:0] map);
      count3 = 3'h0;
      for (int i = 0; i < 4; i++) begin
         count3 = count3 + 3'(map[2*i +: 2] == qdma_pkg::LOG_EP_BULK3);
      end
   endfunction

   function automatic logic [1:0] logical_ep(input logic [2:0] phys,
                                             input logic [7:0] map);
      logic [2:0] slot;
      slot = phys - 3'h2;
      if (phys <= qdma_pkg::PHYS_CTL_HI || phys > qdma_pkg::PHYS_Q_HI) begin
         logical_ep = 2'h0;
      end else begin
         logical_ep = map[2*slot[1:0] +: 2];
      end
   endfunction

   qdma_pkg::ch_cfg_t [3:0] cfg_reg;
   qdma_pkg::stor_mode_t    stor_reg;
   logic [7:0]              place_reg;
   logic [7:0]              epmap_reg;
   logic                    reject_reg;
   logic [3:0]              last_gnt_reg;
   logic [15:0]             rdata_reg;
   logic [15:0]             rdata_next;
   logic                    win_rd_reg;
   logic                    rd_pend_reg;
   logic [3:0]              rd_code_reg;
   logic [7:0]              ram_q;
   logic [7:0]              ram [qdma_pkg::RAM_BYTES];
   qdma_pkg::xfer_word_t    fifo_out;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;

   logic [3:0][1:0]  bidx_w;
   logic [3:0][9:0]  cnt_w;
   logic [3:0][9:0]  wr_w;
   logic [3:0][9:0]  rd_w;
   logic [3:0][9:0]  cap_w;
   logic [3:0][10:0] addr_w;
   logic [3:0]       rx_w;
   logic [3:0]       rx_pend;
   logic [3:0]       tx_pend;
   logic [3:0]       ctl_wr;
   logic [15:0]      src_valid_pad;
   logic [15:0][7:0] src_data_pad;

   // register and window decode
   wire win_hit  = place_reg == qdma_pkg::PLACE_ENABLE &&
                   reg_addr_in >= qdma_pkg::RAM_BASE && reg_addr_in <= qdma_pkg::RAM_LAST;
   wire wr_place = reg_wr_in && reg_addr_in == qdma_pkg::OFF_PLACE;
   wire wr_epmap = reg_wr_in && reg_addr_in == qdma_pkg::OFF_EPMAP;
   wire wr_stor  = reg_wr_in && reg_addr_in == qdma_pkg::OFF_STOR;
   wire wr_stat  = reg_wr_in && reg_addr_in == qdma_pkg::OFF_STAT;
   wire epmap_ok = count3(reg_wdata_in[7:0]) <= 3'h1;
   wire stor_ok  = reg_wdata_in[2:0] <= qdma_pkg::MAX_XFER_MODE;
   wire rej_set  = (wr_epmap && !epmap_ok) || (wr_stor && !stor_ok);
   wire rej_clr  = wr_stat && reg_wdata_in[qdma_pkg::STAT_REJ];
   // any cpu write, or a RAM window read, holds the RAM this cycle; channels simply wait
   wire cpu_busy = reg_wr_in || (reg_rd_in && win_hit);
   wire [10:0] cpu_off = 11'(reg_addr_in - qdma_pkg::RAM_BASE);

   assign src_valid_pad = {4'h0, src_valid_in};
   assign src_data_pad  = {32'h0000_0000, src_data_in};

   for (genvar c = 0; c < 4; c++) begin : g_ch
      localparam int LEAD = c - (c % 2);
      logic       shared;
      logic       absorbed;
      logic       code_ok;
      logic [1:0] b;
      logic [9:0] ptr;
      // follower fills or drains lead buffer
      assign shared   = (c % 2 == 1) && cfg_reg[LEAD].pass;
      assign absorbed = (c % 2 == 1) && cfg_reg[LEAD].pair && !cfg_reg[LEAD].pass;
      assign b        = shared ? 2'(LEAD) : 2'(c);
      assign code_ok  = cfg_reg[c].src <= qdma_pkg::SRC_LAST;
      assign rx_w[c]  = !cfg_reg[c].src[0];
      assign bidx_w[c] = b;
      assign ctl_wr[c] = reg_wr_in && reg_addr_in == qdma_pkg::OFF_CH0 + 16'(c);
      assign rx_pend[c] = cfg_reg[c].en && code_ok && !absorbed && rx_w[c] &&
                          src_valid_pad[cfg_reg[c].src] && cnt_w[b] != cap_w[b];
      assign tx_pend[c] = cfg_reg[c].en && code_ok && !absorbed && !rx_w[c] &&
                          cnt_w[b] != 10'h000 && fifo_in_ready && !rd_pend_reg;
      assign ptr       = rx_w[c] ? wr_w[b] : rd_w[b];
      assign addr_w[c] = 11'(b) * qdma_pkg::REGION_STEP + {1'b0, ptr};
   end

   wire [3:0] pend  = rx_pend | tx_pend;
   wire [3:0] grant = cpu_busy ? 4'h0 : (pend & (~pend + 4'h1));
   wire       gnt_any = |grant;
   wire [1:0] gnt_idx = grant[0] ? 2'h0 : grant[1] ? 2'h1 : grant[2] ? 2'h2 : 2'h3;
   wire       gnt_rx  = rx_w[gnt_idx];
   wire [1:0] gnt_b   = bidx_w[gnt_idx];
   wire [3:0] gnt_src = cfg_reg[gnt_idx].src;

   // per-buffer pointers and fill counts
   for (genvar b = 0; b < 4; b++) begin : g_buf
      logic [9:0] cnt_reg;
      logic [9:0] wr_reg;
      logic [9:0] rd_reg;
      logic       push;
      logic       pop;
      logic       load;
      // even lead with pair spans both regions
      assign cap_w[b] = (b % 2 == 0 && cfg_reg[b].pair) ? qdma_pkg::PAIR_CAP
                                                        : qdma_pkg::REGION_CAP;
      assign push = gnt_any && gnt_rx && gnt_b == 2'(b);
      assign pop  = gnt_any && !gnt_rx && gnt_b == 2'(b);
      assign load = reg_wr_in && reg_addr_in == qdma_pkg::OFF_CNT0 + 16'(b) &&
                    reg_wdata_in[15:10] == 6'h00 && reg_wdata_in[9:0] <= cap_w[b];
      assign cnt_w[b] = cnt_reg;
      assign wr_w[b]  = wr_reg;
      assign rd_w[b]  = rd_reg;
      always_ff @(posedge clk_in) begin
         if (!rst_b_in) begin
            cnt_reg <= 10'h000;
            wr_reg  <= 10'h000;
            rd_reg  <= 10'h000;
         end else if (load) begin
            cnt_reg <= reg_wdata_in[9:0];
            wr_reg  <= reg_wdata_in[9:0] == cap_w[b] ? 10'h000 : reg_wdata_in[9:0];
            rd_reg  <= 10'h000;
         end else if (push) begin
            cnt_reg <= cnt_reg + 10'h001;
            wr_reg  <= wr_reg + 10'h001 == cap_w[b] ? 10'h000 : wr_reg + 10'h001;
         end else if (pop) begin
            cnt_reg <= cnt_reg - 10'h001;
            rd_reg  <= rd_reg + 10'h001 == cap_w[b] ? 10'h000 : rd_reg + 10'h001;
         end
      end
   end

   // engine drives RAM without the processor
   wire        ram_we   = (reg_wr_in && win_hit) || (gnt_any && gnt_rx);
   wire [10:0] ram_addr = (cpu_busy && win_hit) ? cpu_off : addr_w[gnt_idx];
   wire [7:0]  ram_wd   = cpu_busy ? reg_wdata_in[7:0] : src_data_pad[gnt_src];

   always_ff @(posedge clk_in) begin
      if (ram_we) begin
         ram[ram_addr] <= ram_wd;
      end
      ram_q <= ram[ram_addr];
   end

   // transmit path: RAM byte lands in the FIFO one cycle after its grant
   wire                  fifo_out_ready = dst_ready_in[fifo_out.code] && fifo_out_valid;

   stream_fifo #(
      .WIDTH (12),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (rd_pend_reg),
      .in_data_in    ({rd_code_reg, ram_q}),
      .in_ready_out  (fifo_in_ready),
      .out_valid_out (fifo_out_valid),
      .out_data_out  (fifo_out),
      .out_ready_in  (fifo_out_ready)
   );

   assign dst_valid_out     = fifo_out_valid ? one_hot12(fifo_out.code) : 12'h000;
   assign dst_data_out      = fifo_out.data;
   assign src_ready_out     = (gnt_any && gnt_rx) ? one_hot12(gnt_src) : 12'h000;
   assign channel_grant_out = grant;

   // read mux
   always_comb begin
      rdata_next = 16'h0000;
      if (reg_addr_in == qdma_pkg::OFF_PLACE) begin
         rdata_next = {8'h00, place_reg};
      end else if (reg_addr_in == qdma_pkg::OFF_EPMAP) begin
         rdata_next = {8'h00, epmap_reg};
      end else if (reg_addr_in == qdma_pkg::OFF_STOR) begin
         rdata_next = {12'h000, stor_reg};
      end else if (reg_addr_in == qdma_pkg::OFF_STAT) begin
         rdata_next = {7'h00, reject_reg, last_gnt_reg, pend};
      end else if (reg_addr_in[15:2] == qdma_pkg::OFF_CH0[15:2]) begin
         rdata_next = {9'h000, cfg_reg[reg_addr_in[1:0]]};
      end else if (reg_addr_in[15:2] == qdma_pkg::OFF_CNT0[15:2]) begin
         rdata_next = {6'h00, cnt_w[reg_addr_in[1:0]]};
      end
   end

   assign reg_rdata_out = win_rd_reg ? {8'h00, ram_q} : rdata_reg;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         rdata_reg    <= 16'h0000;
         win_rd_reg   <= 1'b0;
         rd_pend_reg  <= 1'b0;
         rd_code_reg  <= 4'h0;
         last_gnt_reg <= 4'h0;
      end else begin
         rdata_reg    <= (reg_rd_in && !win_hit) ? rdata_next : 16'h0000;
         win_rd_reg   <= reg_rd_in && win_hit;
         rd_pend_reg  <= gnt_any && !gnt_rx;
         rd_code_reg  <= gnt_src;
         last_gnt_reg <= gnt_any ? grant : last_gnt_reg;
      end
   end

   // configuration registers; refused writes keep the old value
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         cfg_reg    <= '0;
         place_reg  <= qdma_pkg::PLACE_RST;
         epmap_reg  <= qdma_pkg::EPMAP_RST;
         stor_reg   <= '0;
         reject_reg <= 1'b0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (ctl_wr[c]) begin
               cfg_reg[c] <= qdma_pkg::ch_cfg_t'(reg_wdata_in[6:0] &
                                                 {(c % 2 == 0), 6'h3F});
            end
         end
         place_reg <= wr_place ? reg_wdata_in[7:0] : place_reg;
         // at most one endpoint on logical three
         if (wr_epmap && epmap_ok) begin
            epmap_reg <= reg_wdata_in[7:0];
         end
         if (wr_stor && stor_ok) begin
            stor_reg <= qdma_pkg::stor_mode_t'(reg_wdata_in[3:0]);
         end
         // set wins over clear
         reject_reg <= rej_set || (reject_reg && !rej_clr);
      end
   end

   // endpoint mapping, registered
   wire q_ep = usb_phys_ep_in == qdma_pkg::PHYS_Q_LO || usb_phys_ep_in == qdma_pkg::PHYS_Q_HI;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         usb_logical_ep_out <= 2'h0;
         ep_buf_size_out    <= qdma_pkg::EP_FS_SIZE;
         ep_in_queue_out    <= 1'b0;
      end else begin
         usb_logical_ep_out <= logical_ep(usb_phys_ep_in, epmap_reg);
         // queue RAM only for four and five
         ep_buf_size_out    <= (q_ep && usb_high_speed_in) ? qdma_pkg::EP_HS_SIZE
                                                           : qdma_pkg::EP_FS_SIZE;
         ep_in_queue_out    <= q_ep;
      end
   end

   assign storage_mode_out = stor_reg;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   a_grant_single: assert property ($onehot0(grant))
      else $error("more than one channel granted");
   a_prio_first: assert property (pend[0] && !cpu_busy |-> grant == 4'h1)
      else $error("channel one pending but not granted");
   a_prio_lowest: assert property (grant[3] |-> pend[2:0] == 3'h0)
      else $error("channel four granted over a higher one");
   a_pass_share: assert property (grant[1] && bidx_w[1] == 2'h0 |-> cfg_reg[0].pass)
      else $error("shared buffer drained without pass-through");
   a_pair_cap: assert property (cfg_reg[0].pair |-> cap_w[0] == qdma_pkg::PAIR_CAP)
      else $error("paired buffer not doubled");
   a_src_ready: assert property ((src_ready_out & 12'hAAA) == 12'h000)
      else $error("transmit source offered receive ready");
   a_window_key: assert property (reg_rd_in && reg_addr_in >= qdma_pkg::RAM_BASE &&
         place_reg != qdma_pkg::PLACE_ENABLE |=> reg_rdata_out == 16'h0000)
      else $error("RAM window visible without placement key");
   a_rx_fill: assert property (gnt_any && gnt_rx && gnt_b == 2'h0
         |=> cnt_w[0] == $past(cnt_w[0]) + 10'h001)
      else $error("receive grant did not fill buffer");
   a_tx_fifo: assert property (gnt_any && !gnt_rx |=> rd_pend_reg ##1 !rd_pend_reg
         or gnt_any)
      else $error("transmit grant not forwarded");
   a_ctl_ep: assert property (usb_phys_ep_in <= qdma_pkg::PHYS_CTL_HI
         |=> usb_logical_ep_out == 2'h0)
      else $error("control endpoint mapped away from zero");
   a_ep3_once: assert property (count3(epmap_reg) <= 3'h1)
      else $error("two endpoints on logical three");
   a_hs_size: assert property (q_ep && usb_high_speed_in
         |=> ep_buf_size_out == qdma_pkg::EP_HS_SIZE && ep_in_queue_out)
      else $error("queue endpoint buffer size wrong");
   a_own_size: assert property (!q_ep |=> ep_buf_size_out == qdma_pkg::EP_FS_SIZE)
      else $error("dedicated endpoint buffer size wrong");
   a_mode_range: assert property (stor_reg.mode <= qdma_pkg::MAX_XFER_MODE)
      else $error("storage mode out of range");

   c_pass_xfer: cover property (grant[1] && cfg_reg[0].pass);
   c_all_pend:  cover property (pend == 4'hF);
   c_fifo_full: cover property (!fifo_in_ready);
   c_ep3_map:   cover property (usb_logical_ep_out == 2'h3);
endmodule // queue_dma_usb_ata_bridge

// ==== qdma_pkg.sv ====
/*
 * Shared constants and carrier types for the four-channel queue engine.
 * Assumes a single system clock; offsets are word indices on a plain port.
 */
package qdma_pkg;
   localparam int NUM_CH  = 4;
   localparam int NUM_SRC = 12;

   // request-source codes; odd codes transmit, even codes receive
   localparam logic [3:0] SRC_USB_RX  = 4'h0;
   localparam logic [3:0] SRC_USB_TX  = 4'h1;
   localparam logic [3:0] SRC_STOR_RX = 4'h2;
   localparam logic [3:0] SRC_STOR_TX = 4'h3;
   localparam logic [3:0] SRC_LAST    = 4'hB;

   // queue RAM window and its placement key
   localparam logic [15:0] RAM_BASE     = 16'h2000;
   localparam logic [15:0] RAM_LAST     = 16'h25FF;
   localparam logic [7:0]  PLACE_ENABLE = 8'h21;
   localparam logic [7:0]  PLACE_RST    = 8'h00;
   localparam int          RAM_BYTES    = 1536;
   localparam logic [10:0] REGION_STEP  = 11'h180;
   localparam logic [9:0]  REGION_CAP   = 10'h180;
   localparam logic [9:0]  PAIR_CAP     = 10'h300;

   // register offsets
   localparam logic [15:0] OFF_PLACE = 16'h0000;
   localparam logic [15:0] OFF_EPMAP = 16'h0001;
   localparam logic [15:0] OFF_STOR  = 16'h0002;
   localparam logic [15:0] OFF_STAT  = 16'h0003;
   localparam logic [15:0] OFF_CH0   = 16'h0004;
   localparam logic [15:0] OFF_CNT0  = 16'h0008;
   localparam int          STAT_REJ  = 8;

   // endpoints
   localparam logic [9:0] EP_FS_SIZE   = 10'h040;
   localparam logic [9:0] EP_HS_SIZE   = 10'h200;
   localparam logic [2:0] PHYS_Q_LO    = 3'h4;
   localparam logic [2:0] PHYS_Q_HI    = 3'h5;
   localparam logic [2:0] PHYS_CTL_HI  = 3'h1;
   localparam logic [1:0] LOG_EP_BULK3 = 2'h3;
   localparam logic [7:0] EPMAP_RST    = 8'h00;

   // storage port modes
   localparam logic [2:0] MAX_XFER_MODE = 3'h4;
   localparam int         BURST_MB_S    = 60;

   typedef struct packed {
      logic       pair;
      logic       pass;
      logic       en;
      logic [3:0] src;
   } ch_cfg_t;

   typedef struct packed {
      logic       udma;
      logic [2:0] mode;
   } stor_mode_t;

   typedef struct packed {
      logic [3:0] code;
      logic [7:0] data;
   } xfer_word_t;
endpackage

// ==== stream_fifo.sv ====
/*
 * Synchronous valid/ready FIFO, WIDTH x DEPTH, DEPTH a power of two.
 * Assumes both sides on clk_in; reset is synchronous, active low.
 */
`timescale 1ns/10ps
module stream_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("stream_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;

   assign in_ready_out  = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid_out = cnt_reg != '0;
   assign out_data_out  = mem[rd_reg];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_reg] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_reg + AW'(push);
         rd_reg  <= rd_reg + AW'(pop);
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // stream_fifo

// ==== periph_model.sv ====
/* Stand-in for the peripherals: one byte source on a chosen code, sinks on all codes.
   Assumes the engine's clock; its controls change just after rising edges. */
`timescale 1ns/10ps
module periph_model (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic [11:0]      src_ready_in,
   input  wire logic [11:0]      dst_valid_in,
   input  wire logic [7:0]       dst_data_in,
   input  wire logic [3:0]       code_in,
   input  wire logic [7:0]       send_in,
   input  wire logic             load_in,
   input  wire logic             stall_in,
   output logic      [11:0]      src_valid_out,
   output logic      [11:0][7:0] src_data_out,
   output logic      [11:0]      dst_ready_out,
   output logic      [7:0]       got_count_out
);
   logic [7:0] left_reg  = 8'h00;
   logic [7:0] sent_reg  = 8'h00;
   logic [7:0] noise_reg = 8'h00;
   logic [7:0] got_mem [0:255];
   always_comb begin
      // idle lines churn so a stale byte never looks valid
      for (int i = 0; i < 12; i++) begin
         src_data_out[i] = (i == int'(code_in)) ? 8'h50 + sent_reg : noise_reg;
      end
      src_valid_out = (left_reg != 8'h00) ? 12'h001 << code_in : 12'h000;
      dst_ready_out = stall_in ? 12'h000 : 12'hFFF;
   end
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         left_reg <= 8'h00;
         sent_reg <= 8'h00;
         got_count_out <= 8'h00;
      end else begin
         noise_reg <= noise_reg + 8'h5B;
         if (load_in) begin
            left_reg <= send_in;
         end else if (src_valid_out[code_in] && src_ready_in[code_in]) begin
            left_reg <= left_reg - 8'h01;
            sent_reg <= sent_reg + 8'h01;
         end
         if ((dst_valid_in & dst_ready_out) != 12'h000) begin
            got_mem[got_count_out] <= dst_data_in;
            got_count_out <= got_count_out + 8'h01;
         end
      end
   end
endmodule // periph_model

// ==== tb.sv ====
/* Self-checking bench for the queue engine: register port, endpoint lookup, streams.
   Assumes periph_model on the stream ports and a 25 MHz clock. */
`timescale 1ns/10ps
module tb;
   logic                 clk = 1'b0;
   logic                 rst_b = 1'b0;
   logic [15:0]          addr = 16'h0000, wdata = 16'h0000, rdata, v;
   logic                 wr = 1'b0, rd = 1'b0, hs = 1'b0, load = 1'b0, stall = 1'b0, inq;
   logic [11:0]          src_valid, src_ready, dst_valid, dst_ready, last_dv;
   logic [11:0][7:0]     src_data;
   logic [7:0]           dst_data, got, send = 8'h00, sent = 8'h00, g0;
   logic [3:0]           code = 4'h0, grant, last_g = 4'h0;
   logic [2:0]           phys = 3'h0;
   logic [1:0]           lep;
   logic [9:0]           bsize;
   qdma_pkg::stor_mode_t smode;
   int                   mismatches = 0, check_count = 0;
   logic [16:0]          rows [0:6];
   always #20 clk = ~clk;
   always @(posedge clk) if ((dst_valid & dst_ready) != 12'h000) last_dv <= dst_valid;
   always @(posedge clk) if (grant != 4'h0) last_g <= grant;
   queue_dma_usb_ata_bridge #(.FIFO_DEPTH(8)) queue_dma_usb_ata_bridge_inst (
      .clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .src_valid_in(src_valid),
      .src_data_in(src_data), .src_ready_out(src_ready), .dst_valid_out(dst_valid),
      .dst_data_out(dst_data), .dst_ready_in(dst_ready), .usb_phys_ep_in(phys),
      .usb_high_speed_in(hs), .usb_logical_ep_out(lep), .ep_buf_size_out(bsize),
      .ep_in_queue_out(inq), .storage_mode_out(smode), .channel_grant_out(grant));
   periph_model periph_model_inst (
      .clk_in(clk), .rst_b_in(rst_b), .src_ready_in(src_ready), .dst_valid_in(dst_valid),
      .dst_data_in(dst_data), .code_in(code), .send_in(send), .load_in(load),
      .stall_in(stall), .src_valid_out(src_valid), .src_data_out(src_data),
      .dst_ready_out(dst_ready), .got_count_out(got));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [15:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
      rd_reg(a);
      chk(v, exp);
   endtask
   task automatic feed(input logic [3:0] c, input logic [7:0] n);
      code <= c;
      send <= n;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
   endtask
   task automatic wait_got(input logic [7:0] n);
      for (int i = 0; i < 400 && got !== n; i++) @(posedge clk);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude;
   end
   initial begin
      // rows: phys, high speed, logical, size, in queue; map 0x39 puts phys4 on logical 3
      rows = '{{3'h0, 1'h1, 2'h0, 10'h040, 1'h0}, {3'h1, 1'h0, 2'h0, 10'h040, 1'h0},
               {3'h2, 1'h1, 2'h1, 10'h040, 1'h0}, {3'h3, 1'h0, 2'h2, 10'h040, 1'h0},
               {3'h4, 1'h1, 2'h3, 10'h200, 1'h1}, {3'h4, 1'h0, 2'h3, 10'h040, 1'h1},
               {3'h5, 1'h1, 2'h0, 10'h200, 1'h1}};
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rchk(qdma_pkg::OFF_PLACE, 16'h0000);
      rchk(qdma_pkg::OFF_EPMAP, 16'h0000);
      rchk(qdma_pkg::OFF_STAT, 16'h0000);
      chk({3'h0, lep, bsize, inq}, 16'h0080);
      rchk(16'h2000, 16'h0000);
      wr_reg(qdma_pkg::OFF_PLACE, 16'h0021);
      rchk(qdma_pkg::OFF_PLACE, 16'h0021);
      wr_reg(16'h25FF, 16'h005A);
      rchk(16'h25FF, 16'h005A);
      rchk(16'h2600, 16'h0000);
      wr_reg(qdma_pkg::OFF_EPMAP, 16'h0039);
      for (int i = 0; i < 7; i++) begin
         phys <= rows[i][16:14];
         hs <= rows[i][13];
         repeat (2) @(posedge clk);
         #1 chk({3'h0, lep, bsize, inq}, {3'h0, rows[i][12:0]});
      end
      // four fields on logical 3 must be refused
      wr_reg(qdma_pkg::OFF_EPMAP, 16'h00FF);
      rchk(qdma_pkg::OFF_EPMAP, 16'h0039);
      rd_reg(qdma_pkg::OFF_STAT);
      chk(v & 16'h0100, 16'h0100);
      wr_reg(qdma_pkg::OFF_STAT, 16'h0100);
      rd_reg(qdma_pkg::OFF_STAT);
      chk(v & 16'h0100, 16'h0000);
      wr_reg(qdma_pkg::OFF_STOR, 16'h0004);
      chk(16'(smode), 16'h0004);
      wr_reg(qdma_pkg::OFF_STOR, 16'h000C);
      chk(16'(smode), 16'h000C);
      wr_reg(qdma_pkg::OFF_STOR, 16'h000D);
      chk(16'(smode), 16'h000C);
      for (int c = 0; c < 12; c++) begin
         wr_reg(qdma_pkg::OFF_CH0, 16'h0000);
         if (c[0] == 1'b0) begin
            wr_reg(qdma_pkg::OFF_CNT0, 16'h0000);
            feed(4'(c), 8'h01);
            wr_reg(qdma_pkg::OFF_CH0, 16'h0010 | 16'(c));
            for (int i = 0; i < 100 && src_valid !== 12'h000; i++) @(posedge clk);
            rchk(qdma_pkg::OFF_CNT0, 16'h0001);
            rchk(16'h2000, {8'h00, 8'h50 + sent});
            sent = sent + 8'h01;
            rd_reg(qdma_pkg::OFF_STAT);
            chk(v & 16'h00FF, 16'h0010);
         end else begin
            g0 = got;
            wr_reg(16'h2000, {8'h00, 8'hA0 + 8'(c)});
            wr_reg(qdma_pkg::OFF_CNT0, 16'h0001);
            wr_reg(qdma_pkg::OFF_CH0, 16'h0010 | 16'(c));
            wait_got(g0 + 8'h01);
            chk({8'h00, periph_model_inst.got_mem[g0]}, {8'h00, 8'hA0 + 8'(c)});
            chk({4'h0, last_dv}, 16'h0001 << c);
            rchk(qdma_pkg::OFF_CNT0, 16'h0000);
         end
      end
      wr_reg(qdma_pkg::OFF_CH0, 16'h0000);
      // storage transmit on the follower, USB receive on the lead
      wr_reg(qdma_pkg::OFF_CH0 + 16'h0001, 16'h0010 | 16'(qdma_pkg::SRC_STOR_TX));
      wr_reg(qdma_pkg::OFF_CNT0, 16'h0000);
      stall <= 1'b1;
      g0 = got;
      feed(qdma_pkg::SRC_USB_RX, 8'h0C);
      wr_reg(qdma_pkg::OFF_CH0, 16'h0030 | 16'(qdma_pkg::SRC_USB_RX));
      for (int i = 0; i < 200 && src_valid !== 12'h000; i++) @(posedge clk);
      // settle time for the FIFO to fill against the stalled sink
      repeat (40) @(posedge clk);
      chk(16'(got), 16'(g0));
      rchk(qdma_pkg::OFF_CNT0, 16'h0004);
      stall <= 1'b0;
      wait_got(g0 + 8'h0C);
      for (int i = 0; i < 12; i++) begin
         chk({8'h00, periph_model_inst.got_mem[g0 + i]}, {8'h00, 8'h50 + sent + 8'(i)});
      end
      rchk(qdma_pkg::OFF_CNT0, 16'h0000);
      // read path: storage receive on four, USB transmit on three
      g0 = got;
      wr_reg(qdma_pkg::OFF_CH0 + 16'h0003, 16'h0010 | 16'(qdma_pkg::SRC_STOR_RX));
      wr_reg(qdma_pkg::OFF_CH0 + 16'h0002, 16'h0030 | 16'(qdma_pkg::SRC_USB_TX));
      feed(qdma_pkg::SRC_STOR_RX, 8'h04);
      wait_got(g0 + 8'h04);
      for (int i = 0; i < 4; i++) begin
         chk({8'h00, periph_model_inst.got_mem[g0 + i]}, {8'h00, 8'h5C + sent + 8'(i)});
      end
      chk({last_dv, last_g}, 16'h0024);
      wr_reg(qdma_pkg::OFF_CNT0, 16'(qdma_pkg::REGION_CAP) + 16'h0001);
      rchk(qdma_pkg::OFF_CNT0, 16'h0000);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rchk(qdma_pkg::OFF_PLACE, 16'h0000);
      rchk(16'h2000, 16'h0000);
      conclude;
   end
endmodule // tb
